// ### logic/rhpmx_regs.sv
// APB register slice for the right headphone mixer and driver controls
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module rhpmx_regs (
   input  wire logic                            i_clk_sys,
   input  wire logic                            i_resetn,
   input  wire logic                            i_psel,
   input  wire logic                            i_penable,
   input  wire logic                            i_pwrite,
   input  wire logic [rhpmx_pkg::ADDR_W-1:0]    i_paddr,
   input  wire logic [rhpmx_pkg::DATA_W-1:0]    i_pwdata,
   input  wire logic [3:0]                      i_pstrb,
   output logic                                 o_pready,
   output logic      [rhpmx_pkg::DATA_W-1:0]    o_prdata,
   output logic                                 o_pslverr,
   output logic      [rhpmx_pkg::MIX_N-1:0]     o_mix_route,
   output logic      [rhpmx_pkg::MIX_N-1:0][6:0] o_mix_vol,
   output logic      [3:0]                      o_hp_level,
   output logic                                 o_hp_unmute,
   output logic                                 o_hp_pd_hiz,
   output logic                                 o_hp_power,
   output logic                                 o_gain_pending
);
   import rhpmx_pkg::*;

   // ****************************************
   // Address decode
   // ****************************************
   logic [9:0]       word_idx;
   logic [MIX_N-1:0] mix_hit;
   logic             ctrl_hit;
   logic             any_hit;
   logic             setup_ph;
   logic             wr_en;
   logic             gain_wr;
   logic [7:0]       mix_reg [MIX_N];
   logic [7:0]       rd_byte;
   logic [4:0]       gain_cnt;
   logic [4:0]       next_gain_cnt;

   assign word_idx = i_paddr[11:2];
   assign ctrl_hit = (word_idx == IDX_RIGHT_HP_OUTPUT_LEVEL_CTRL);
   assign any_hit  = ctrl_hit | (|mix_hit);
   assign setup_ph = i_psel & ~i_penable;
   // Only the low byte lane carries register data
   assign wr_en    = i_psel & i_penable & o_pready & i_pwrite & i_pstrb[0];
   assign gain_wr  = wr_en & any_hit;

   // ****************************************
   // Mixer-input registers
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < MIX_N; g++) begin : g_mix
         assign mix_hit[g] = (word_idx == MIX_IDX[g]);
         always_ff @(posedge i_clk_sys) begin
            if (!i_resetn) begin
               mix_reg[g] <= MIX_RST;
            end else if (wr_en && mix_hit[g]) begin
               mix_reg[g] <= i_pwdata[7:0];
            end
         end
         assign o_mix_route[g] = mix_reg[g][ROUTE_BIT];
         assign o_mix_vol[g]   = mix_reg[g][VOL_MSB:0];
      end
   endgenerate

   // ****************************************
   // Output level control register
   // ****************************************
   // Level codes 10-15 are stored as written; keeping them out is software's job.
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_hp_level  <= LEVEL_RST;
         o_hp_unmute <= MUTE_RST;
         o_hp_pd_hiz <= HIZ_RST;
         o_hp_power  <= PWR_RST;
      end else if (wr_en && ctrl_hit) begin
         o_hp_level  <= i_pwdata[LEVEL_MSB:LEVEL_LSB];
         o_hp_unmute <= i_pwdata[MUTE_BIT];
         o_hp_pd_hiz <= i_pwdata[HIZ_BIT];
         o_hp_power  <= i_pwdata[PWR_BIT];
      end
   end

   // ****************************************
   // Gain application status
   // ****************************************
   // Any new gain setting restarts the ramp; a write in the last cycle of
   // a ramp therefore never lets the bit fall early.
   always_comb begin
      next_gain_cnt = gain_cnt;
      if (gain_wr) begin
         next_gain_cnt = GAIN_APPLY_CNT;
      end else if (gain_cnt != 5'h00) begin
         next_gain_cnt = gain_cnt - 5'h01;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         gain_cnt       <= GAIN_APPLY_CNT;
         o_gain_pending <= STAT_RST;
      end else begin
         gain_cnt       <= next_gain_cnt;
         o_gain_pending <= (next_gain_cnt != 5'h00);
      end
   end

   // ****************************************
   // APB answer
   // ****************************************
   always_comb begin
      rd_byte = 8'h00;
      for (int k = 0; k < MIX_N; k++) begin
         if (mix_hit[k]) begin
            rd_byte = mix_reg[k];
         end
      end
      if (ctrl_hit) begin
         rd_byte = {o_hp_level, o_hp_unmute, o_hp_pd_hiz, o_gain_pending, o_hp_power};
      end
   end

   // One wait-free access phase: ready is raised by the setup cycle
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_pready  <= 1'h0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'h0;
      end else begin
         o_pready  <= setup_ph;
         o_pslverr <= setup_ph & ~any_hit;
         if (setup_ph && !i_pwrite) begin
            o_prdata <= {24'h00_0000, rd_byte};
         end else if (setup_ph) begin
            o_prdata <= 32'h0000_0000;
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   logic [5:0] idle_cnt;

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn || gain_wr) begin
         idle_cnt <= 6'h00;
      end else if (idle_cnt != 6'h3f) begin
         idle_cnt <= idle_cnt + 6'h01;
      end
   end

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_resetn);

   generate
      for (g = 0; g < MIX_N; g++) begin : g_chk
         // The write data is compared one cycle late; a back-to-back transfer may
         // already have put new data on the bus, so the check reaches back with $past.
         mix_route_a: assert property (wr_en && mix_hit[g] |=>
            o_mix_route[g] == $past(i_pwdata[ROUTE_BIT]) ##1 $stable(o_mix_route[g]))
            else $error("route bit does not follow write");

         vol_follow_a: assert property (wr_en && mix_hit[g] |=>
            o_mix_vol[g] == $past(i_pwdata[VOL_MSB:0]))
            else $error("volume field does not follow write");

         mix_hold_a: assert property (!(wr_en && mix_hit[g]) |=>
            $stable(o_mix_route[g]) && $stable(o_mix_vol[g]))
            else $error("mixer input changed without a write");
      end
   endgenerate

   mix_vol_a: assert property (wr_en && mix_hit[0] |=>
      o_mix_vol[0] == $past(i_pwdata[6:0]))
      else $error("volume field does not follow write");

   hp_level_a: assert property (wr_en && ctrl_hit |=>
      o_hp_level == $past(i_pwdata[7:4]))
      else $error("output level does not follow write");

   hp_mute_a: assert property (!(wr_en && ctrl_hit) |=> $stable(o_hp_unmute))
      else $error("mute changed without a write");

   pd_hiz_a: assert property (wr_en && ctrl_hit |=>
      o_hp_pd_hiz == $past(i_pwdata[2]))
      else $error("power-down style does not follow write");

   gain_busy_a: assert property (idle_cnt < 6'(GAIN_APPLY_CYC) |-> o_gain_pending)
      else $error("status fell before gains applied");

   gain_done_a: assert property (idle_cnt >= 6'(GAIN_APPLY_CYC) |-> !o_gain_pending)
      else $error("status still set after gains applied");

   hp_power_a: assert property (wr_en && ctrl_hit |=>
      o_hp_power == $past(i_pwdata[0]))
      else $error("power bit does not follow write");

   stat_ro_a: assert property (wr_en && ctrl_hit && !i_pwdata[1] |=> o_gain_pending)
      else $error("status bit took written value");

   apb_ready_a: assert property (setup_ph |=> o_pready ##1 !o_pready)
      else $error("ready not one cycle after setup");

   // ****************************************
   // Control register hold and bus answer
   // ****************************************
   // The analog stage sees these bits directly, so any stray change
   // would be an audible glitch; they may move only on an accepted write.
   ctrl_hold_a: assert property (!(wr_en && ctrl_hit) |=>
      $stable(o_hp_level) && $stable(o_hp_pd_hiz) && $stable(o_hp_power))
      else $error("output level control changed without a write");

   wr_pending_a: assert property (gain_wr |=> o_gain_pending)
      else $error("status not set after a gain write");

   slverr_ready_a: assert property (o_pslverr |-> o_pready)
      else $error("error raised outside the access phase");

   rdata_upper_a: assert property (o_pready |-> o_prdata[31:8] == 24'h00_0000)
      else $error("read data upper lanes not zero");

   // A write whose low lane strobe is off must not reach any register.
   lane_off_a: assert property (i_psel && i_penable && o_pready && i_pwrite &&
      !i_pstrb[0] |=> $stable(o_hp_level) && $stable(o_mix_route))
      else $error("write without low lane strobe took effect");

   route_wr_c: cover property (wr_en && mix_hit[3] && i_pwdata[7]);
   gain_fall_c: cover property (o_gain_pending ##1 !o_gain_pending);
   unmapped_c: cover property (o_pready && o_pslverr);
   ctrl_rd_c: cover property (setup_ph && !i_pwrite && ctrl_hit);

endmodule

// ### logic/rhpmx_pkg.sv
// Constants for the right headphone mixer control register slice
package rhpmx_pkg;

   // ****************************************
   // Bus geometry
   // ****************************************
   localparam int          ADDR_W = 12;
   localparam int          DATA_W = 32;
   localparam int          MIX_N  = 8;

   // ****************************************
   // Register indexes (byte address is four times the index)
   // ****************************************
   localparam logic [9:0] IDX_LEFT_DAC_TO_RIGHT_HP_VOL     = 10'h03d;
   localparam logic [9:0] IDX_RIGHT_LINE2_TO_RIGHT_HP_VOL  = 10'h03e;
   localparam logic [9:0] IDX_RIGHT_AMP_TO_RIGHT_HP_VOL    = 10'h03f;
   localparam logic [9:0] IDX_RIGHT_DAC_TO_RIGHT_HP_VOL    = 10'h040;
   localparam logic [9:0] IDX_RIGHT_HP_OUTPUT_LEVEL_CTRL   = 10'h041;
   localparam logic [9:0] IDX_LEFT_LINE2_TO_RIGHT_COM_VOL  = 10'h042;
   localparam logic [9:0] IDX_LEFT_AMP_TO_RIGHT_COM_VOL    = 10'h043;
   localparam logic [9:0] IDX_LEFT_DAC_TO_RIGHT_COM_VOL    = 10'h044;
   localparam logic [9:0] IDX_RIGHT_LINE2_TO_RIGHT_COM_VOL = 10'h045;

   // Mixer-input registers in port order 0..7
   localparam logic [9:0] MIX_IDX [MIX_N] = '{
      IDX_LEFT_DAC_TO_RIGHT_HP_VOL,
      IDX_RIGHT_LINE2_TO_RIGHT_HP_VOL,
      IDX_RIGHT_AMP_TO_RIGHT_HP_VOL,
      IDX_RIGHT_DAC_TO_RIGHT_HP_VOL,
      IDX_LEFT_LINE2_TO_RIGHT_COM_VOL,
      IDX_LEFT_AMP_TO_RIGHT_COM_VOL,
      IDX_LEFT_DAC_TO_RIGHT_COM_VOL,
      IDX_RIGHT_LINE2_TO_RIGHT_COM_VOL
   };

   // ****************************************
   // Field positions
   // ****************************************
   localparam int          ROUTE_BIT = 7;
   localparam int          VOL_MSB   = 6;
   localparam int          LEVEL_MSB = 7;
   localparam int          LEVEL_LSB = 4;
   localparam int          MUTE_BIT  = 3;
   localparam int          HIZ_BIT   = 2;
   localparam int          STAT_BIT  = 1;
   localparam int          PWR_BIT   = 0;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] MIX_RST   = 8'h00;
   localparam logic [3:0] LEVEL_RST = 4'h0;
   localparam logic       MUTE_RST  = 1'h0;
   localparam logic       HIZ_RST   = 1'h1;
   localparam logic       STAT_RST  = 1'h1;
   localparam logic       PWR_RST   = 1'h0;

   // ****************************************
   // Timing
   // ****************************************
   localparam int          CLK_PERIOD_NS  = 4;
   localparam int          GAIN_APPLY_NS  = 64;
   localparam int          GAIN_APPLY_CYC =
      (GAIN_APPLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] GAIN_APPLY_CNT = 5'(GAIN_APPLY_CYC);

endpackage

// ### verification/right_headphone_mix_ctrl_regs_bench.sv
// Self-checking bench for the right headphone mixer control register slice
`timescale 1ns/1ps
module right_headphone_mix_ctrl_regs_bench;
   import rhpmx_pkg::*;

   typedef struct packed {
      logic [9:0] idx;
      logic [7:0] wd;
      logic [7:0] rd;
   } rhpmx_row_type;

   logic                    i_clk_sys = 1'b0;
   logic                    i_resetn  = 1'b0;
   logic                    i_psel    = 1'b0;
   logic                    i_penable = 1'b0;
   logic                    i_pwrite  = 1'b0;
   logic [ADDR_W-1:0]       i_paddr   = '0;
   logic [DATA_W-1:0]       i_pwdata  = '0;
   logic [3:0]              i_pstrb   = 4'hf;
   logic                    o_pready;
   logic [DATA_W-1:0]       o_prdata;
   logic                    o_pslverr;
   logic [MIX_N-1:0]        o_mix_route;
   logic [MIX_N-1:0][6:0]   o_mix_vol;
   logic [3:0]              o_hp_level;
   logic                    o_hp_unmute;
   logic                    o_hp_pd_hiz;
   logic                    o_hp_power;
   logic                    o_gain_pending;
   logic [31:0]             d;
   logic                    e;
   int                      n_errors    = 0;
   int                      check_count = 0;
   // Status bit reads one in the level rows: the gain ramp is still running
   rhpmx_row_type           rows [11] = '{
      '{10'h03d, 8'h80, 8'h80}, '{10'h03e, 8'hff, 8'hff}, '{10'h03f, 8'h7f, 8'h7f},
      '{10'h040, 8'h81, 8'h81}, '{10'h042, 8'haa, 8'haa}, '{10'h043, 8'h55, 8'h55},
      '{10'h044, 8'hc0, 8'hc0}, '{10'h045, 8'h3f, 8'h3f}, '{10'h041, 8'h9d, 8'h9f},
      '{10'h041, 8'h0a, 8'h0a}, '{10'h03d, 8'h00, 8'h00}};

   rhpmx_regs u_dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .i_pstrb(i_pstrb), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
      .o_mix_route(o_mix_route), .o_mix_vol(o_mix_vol), .o_hp_level(o_hp_level),
      .o_hp_unmute(o_hp_unmute), .o_hp_pd_hiz(o_hp_pd_hiz), .o_hp_power(o_hp_power),
      .o_gain_pending(o_gain_pending));

   always #2 i_clk_sys = ~i_clk_sys;

   // ****************************************
   // Tasks
   // ****************************************
   task automatic results();
      if (n_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Holds the request until pready is seen high; the wait is bounded
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                      input logic [3:0] st);
      int n;
      @(posedge i_clk_sys);
      i_psel   <= 1'b1;
      i_pwrite <= wr;
      i_paddr  <= {idx, 2'b00};
      i_pwdata <= {24'h0, wd};
      i_pstrb  <= st;
      @(posedge i_clk_sys);
      i_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      d = o_prdata;
      e = o_pslverr;
      if (n >= 20)
         n_errors++;
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
   endtask

   task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00, 4'hf);
      chk({e, d}, {1'b0, 24'h0, exp});
   endtask

   task automatic rst_chk();
      #1;
      chk({o_mix_route, o_mix_vol, o_pready, o_pslverr}, '0);
      chk({o_hp_level, o_hp_unmute, o_hp_pd_hiz, o_gain_pending, o_hp_power}, 8'h06);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      rst_chk();
      rdc(IDX_RIGHT_HP_OUTPUT_LEVEL_CTRL, 8'h06);
      for (int j = 0; j < MIX_N; j++)
         rdc(MIX_IDX[j], 8'h00);
      foreach (rows[r]) begin
         apb(1'b1, rows[r].idx, rows[r].wd, 4'hf);
         rdc(rows[r].idx, rows[r].rd);
         #1;
         for (int j = 0; j < MIX_N; j++)
            if (MIX_IDX[j] == rows[r].idx)
               chk({o_mix_route[j], o_mix_vol[j]}, rows[r].rd);
         if (rows[r].idx == IDX_RIGHT_HP_OUTPUT_LEVEL_CTRL)
            chk({o_hp_level, o_hp_unmute, o_hp_pd_hiz, o_gain_pending, o_hp_power}, rows[r].rd);
      end
      // Gain ramp runs 16 cycles from the write edge
      apb(1'b1, IDX_RIGHT_HP_OUTPUT_LEVEL_CTRL, 8'h02, 4'hf);
      repeat (12) @(posedge i_clk_sys);
      #1;
      chk(o_gain_pending, 1'b1);
      repeat (8) @(posedge i_clk_sys);
      #1;
      chk(o_gain_pending, 1'b0);
      rdc(IDX_RIGHT_HP_OUTPUT_LEVEL_CTRL, 8'h00);
      apb(1'b1, 10'h03d, 8'hff, 4'he);
      rdc(10'h03d, 8'h00);
      apb(1'b0, 10'h046, 8'h00, 4'hf);
      chk({e, d}, {1'b1, 32'h0});
      apb(1'b1, 10'h03c, 8'hff, 4'hf);
      chk(e, 1'b1);
      // Second reset in mid-run must restore every control
      apb(1'b1, 10'h045, 8'hff, 4'hf);
      i_resetn <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      rst_chk();
      rdc(10'h045, 8'h00);
      results();
   end

   initial begin
      repeat (3000) @(posedge i_clk_sys);
      n_errors++;
      results();
   end
endmodule
